// file: rtl/ptr_interp.sv
// receive pointer interpreter: event counters, state machine, outputs
// assumes PTR_VALID pulses once per frame with the pointer bytes
// from framing logic on MCLK; provisioned type is quasi-static
`include "ptr_defines.svh"
`default_nettype none
module ptr_interp #(
	parameter logic [1:0] SS_TU11 = 2'h3
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// received pointer
	input wire logic PTR_VALID,
	input wire logic [7:0] PTR_H1,
	input wire logic [7:0] PTR_H2,
	// provisioning
	input wire ptr_pkg::ptr_type_t PTR_TYPE,
	input wire logic TYPE_MISMATCH,
	// defects and offset
	output logic AIS_DEFECT,
	output logic LOP_DEFECT,
	output logic [9:0] ACT_OFFSET,
	output logic OFFSET_VALID,
	output logic OFFSET_JUMP,
	output ptr_pkg::ptr_state_t STATE
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	ptr_evt_if ev ();
	ptr_pkg::ptr_state_t st_q, st_d;
	logic [9:0] off_q, off_d, cand_q;
	logic off_def_q;
	logic [`PTR_CNT_W-1:0] ais_cnt_q, inv_cnt_q, ndf_cnt_q, new_cnt_q, hold_q;
	logic f, inv, eq3, ais3, inv8, ndf8, acc, chg, keep_new, adj;

	// ---------------------------------------------------------------
	// classification
	// ---------------------------------------------------------------
	ptr_classify #(
		.SS_TU11(SS_TU11)
	) u_cls (
		.h1(PTR_H1),
		.h2(PTR_H2),
		.ptype(PTR_TYPE),
		.type_mism(TYPE_MISMATCH),
		.act_off(off_q),
		.off_def(off_def_q),
		.ev(ev.cls)
	);

	assign f = PTR_VALID;
	// inc and dec only count as valid while in the normal state
	assign inv = !ev.norm && !ev.ndfe && !ev.ais
		&& !((ev.inc || ev.dec) && st_q == ptr_pkg::PTR_NORM);
	assign eq3 = ev.newp && (new_cnt_q == `PTR_NEW_RUN - 4'h1)
		&& (ev.rx_off == cand_q);
	assign ais3 = ev.ais && (ais_cnt_q == `PTR_AIS_RUN - 4'h1);
	assign inv8 = inv && (inv_cnt_q == `PTR_INV_RUN - 4'h1);
	assign ndf8 = ev.ndfe && (ndf_cnt_q == `PTR_NDF_RUN - 4'h1);
	assign adj = st_q == ptr_pkg::PTR_INC || st_q == ptr_pkg::PTR_DEC
		|| st_q == ptr_pkg::PTR_NDF;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		acc = 1'b0;
		if (f) begin
			if (eq3) begin
				st_d = ptr_pkg::PTR_NORM;
				acc = 1'b1;
			end else if (ais3 && st_q != ptr_pkg::PTR_AIS) begin
				st_d = ptr_pkg::PTR_AIS;
			end else if (inv8 && st_q != ptr_pkg::PTR_LOP) begin
				st_d = ptr_pkg::PTR_LOP;
			end else if (ndf8 && (st_q == ptr_pkg::PTR_NORM
				|| st_q == ptr_pkg::PTR_NDF)) begin
				st_d = ptr_pkg::PTR_LOP;
			end else if (ev.ndfe) begin
				st_d = ptr_pkg::PTR_NDF;
				acc = 1'b1;
			end else begin
				unique case (st_q)
					ptr_pkg::PTR_NORM: begin
						if (ev.inc)
							st_d = ptr_pkg::PTR_INC;
						else if (ev.dec)
							st_d = ptr_pkg::PTR_DEC;
					end
					ptr_pkg::PTR_INC, ptr_pkg::PTR_DEC, ptr_pkg::PTR_NDF: begin
						if (hold_q == `PTR_HOLD_RUN - 4'h1)
							st_d = ptr_pkg::PTR_NORM;
					end
					ptr_pkg::PTR_AIS, ptr_pkg::PTR_LOP: ;
				endcase
			end
		end
	end

	assign chg = st_d != st_q;
	// among the normal and adjust states the new-pointer run survives
	assign keep_new = (st_q == ptr_pkg::PTR_NORM || adj)
		&& (st_d == ptr_pkg::PTR_NORM || st_d == ptr_pkg::PTR_INC
		|| st_d == ptr_pkg::PTR_DEC || st_d == ptr_pkg::PTR_NDF);

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			st_q <= ptr_pkg::PTR_LOP;
		else
			st_q <= st_d;
	end

	// frames spent in an adjust state; restarts on every entry
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			hold_q <= '0;
		else if (f && (chg || acc))
			hold_q <= '0;
		else if (f && adj)
			hold_q <= hold_q + 4'h1;
	end

	// ---------------------------------------------------------------
	// active offset
	// ---------------------------------------------------------------
	always_comb begin
		off_d = off_q;
		if (acc)
			off_d = ev.rx_off;
		else if (f && st_q == ptr_pkg::PTR_NORM && st_d == ptr_pkg::PTR_INC)
			off_d = (off_q >= ev.max_off) ? 10'h000 : off_q + 10'h001;
		else if (f && st_q == ptr_pkg::PTR_NORM && st_d == ptr_pkg::PTR_DEC)
			off_d = (off_q == 10'h000) ? ev.max_off : off_q - 10'h001;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N)
			off_q <= 10'h000;
		else
			off_q <= off_d;
	end

	// offset is undefined once AIS or LOP is entered
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			off_def_q <= 1'b0;
		else if (acc)
			off_def_q <= 1'b1;
		else if (st_d == ptr_pkg::PTR_AIS || st_d == ptr_pkg::PTR_LOP)
			off_def_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// consecutive event counters
	// ---------------------------------------------------------------
	// AIS run: not touched by state changes
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			ais_cnt_q <= '0;
		else if (f && !ev.ais)
			ais_cnt_q <= '0;
		else if (f && ais_cnt_q != `PTR_AIS_RUN)
			ais_cnt_q <= ais_cnt_q + 4'h1;
	end

	// invalid run: counts in every state, cleared by three equal news or any frame that is not invalid
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			inv_cnt_q <= '0;
		else if (f && (eq3 || !inv))
			inv_cnt_q <= '0;
		else if (f && inv_cnt_q != `PTR_INV_RUN)
			inv_cnt_q <= inv_cnt_q + 4'h1;
	end

	// NDF-enable run: cleared on the AIS to NDF step and by any frame without NDF enable
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			ndf_cnt_q <= '0;
		else if (f && st_q == ptr_pkg::PTR_AIS && st_d == ptr_pkg::PTR_NDF)
			ndf_cnt_q <= '0;
		else if (f && !ev.ndfe)
			ndf_cnt_q <= '0;
		else if (f && ndf_cnt_q != `PTR_NDF_RUN)
			ndf_cnt_q <= ndf_cnt_q + 4'h1;
	end

	// new-pointer run and the offset it must repeat
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			new_cnt_q <= '0;
			cand_q <= 10'h000;
		end else if (f) begin
			if (eq3 || (chg && !keep_new) || !ev.newp) begin
				new_cnt_q <= '0;
			end else if (new_cnt_q == 4'h0 || ev.rx_off != cand_q) begin
				new_cnt_q <= 4'h1;
				cand_q <= ev.rx_off;
			end else begin
				new_cnt_q <= new_cnt_q + 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			STATE <= ptr_pkg::PTR_LOP;
			AIS_DEFECT <= 1'b0;
			LOP_DEFECT <= 1'b1;
			OFFSET_VALID <= 1'b0;
		end else begin
			STATE <= st_d;
			AIS_DEFECT <= st_d == ptr_pkg::PTR_AIS;
			LOP_DEFECT <= st_d == ptr_pkg::PTR_LOP;
			OFFSET_VALID <= st_d == ptr_pkg::PTR_NORM;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			ACT_OFFSET <= 10'h000;
			OFFSET_JUMP <= 1'b0;
		end else begin
			ACT_OFFSET <= off_d;
			// frame offset discontinuity for the downstream elastic store
			OFFSET_JUMP <= acc && (ev.rx_off != off_q || !off_def_q);
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_ais_third;
		f && ais3 && st_q != ptr_pkg::PTR_AIS;
	endsequence

	sequence s_inv_eighth;
		f && inv8 && !eq3 && st_q != ptr_pkg::PTR_LOP;
	endsequence

	sequence s_norm_inc;
		f && st_q == ptr_pkg::PTR_NORM && ev.inc && !ev.ais && !eq3;
	endsequence

	ais_entry_a: assert property (s_ais_third |=> AIS_DEFECT && !OFFSET_VALID)
		else $error("three AIS frames did not enter AIS");

	lop_entry_a: assert property ((s_inv_eighth and !ais3) |=> LOP_DEFECT)
		else $error("eight invalid frames did not enter LOP");

	lop_cause_a: assert property ($rose(LOP_DEFECT) && !$past(ndf8)
		|-> $past(inv_cnt_q) == `PTR_INV_RUN - 4'h1)
		else $error("LOP entered without eight consecutive invalid frames");

	eq_new_a: assert property (f && eq3 |=> STATE == ptr_pkg::PTR_NORM
		&& inv_cnt_q == 4'h0 && ACT_OFFSET == $past(ev.rx_off))
		else $error("three equal new pointers not accepted");

	eq_need_a: assert property (f && acc && !ev.ndfe |-> ev.newp
		&& new_cnt_q == 4'h2 && cand_q == ev.rx_off)
		else $error("new offset accepted without a run of equal pointers");

	inc_step_a: assert property (s_norm_inc ##1 1'b1 |-> STATE == ptr_pkg::PTR_INC
		&& (ACT_OFFSET == $past(off_q) + 10'h001 || ACT_OFFSET == 10'h000))
		else $error("increment not applied");

	dec_step_a: assert property (f && st_q == ptr_pkg::PTR_NORM && ev.dec && !eq3
		|=> STATE == ptr_pkg::PTR_DEC
		&& (ACT_OFFSET == $past(off_q) - 10'h001 || $past(off_q) == 10'h000))
		else $error("decrement not applied");

	ndf_acc_a: assert property (f && ev.ndfe && !eq3 && !ais3 && !inv8 && !ndf8
		|=> STATE == ptr_pkg::PTR_NDF && ACT_OFFSET == $past(ev.rx_off))
		else $error("NDF enable not accepted");

	valid_flag_a: assert property (OFFSET_VALID == (STATE == ptr_pkg::PTR_NORM)
		&& AIS_DEFECT == (STATE == ptr_pkg::PTR_AIS))
		else $error("valid flag disagrees with state");

	hold_exit_a: assert property (f && adj && hold_q == 4'h2 && ev.norm
		&& !ais3 && !inv8 |=> STATE == ptr_pkg::PTR_NORM)
		else $error("adjust state did not return to normal");

	inv_keep_a: assert property (f && inv && !eq3 && inv_cnt_q < 4'h7 && chg
		|=> inv_cnt_q == $past(inv_cnt_q) + 4'h1)
		else $error("invalid run lost on state change");
endmodule // ptr_interp
`default_nettype wire

// file: rtl/ptr_defines.svh
// constants for the receive pointer interpreter
// assumes one pointer word is presented per frame on the block clock
//
// Functional notes
// - six states: normal, AIS, LOP, increment, decrement, NDF
// - NDF enabled codes 1001,0001,1101,1011,1000
// - NDF disabled codes 0110,1110,0010,0100,0111
// - other NDF codes invalid, except within AIS
// - both pointer bytes all ones means AIS
// - normal pointer: NDF disabled, offset equals active
// - NDF enable: NDF enabled, offset in range
// - increment: I-bits majority inverted, D-bits not
// - decrement: D-bits majority inverted, I-bits not
// - tributary events other than AIS also require matching ss-bits
// - expected ss-bits 10, 00 for TU-2, SS_TU11 (default 11) for TU-11
// - AU-4 and AU-4-Xc ignore the ss-bits
// - anything else invalid; inc/dec valid only normally
// - three consecutive AIS frames enter AIS
// - eight consecutive invalid frames enter LOP, as do eight NDF enables
// - new pointer: in range, differs; also invalid
// - accept offset after three equal new pointers
// - three equal new pointers win, clear invalids
// - new counter cleared on state change, mostly
// - invalid counter survives state changes
// - AIS counter kept; NDF counter cleared AIS-to-NDF
// - active offset valid only in normal state
// - type mismatch persisting leads to LOP
`ifndef PTR_DEFINES_SVH
`define PTR_DEFINES_SVH

// ---------------------------------------------------------------
// pointer word layout
// ---------------------------------------------------------------
`define PTR_AIS_WORD 16'hFFFF
`define PTR_NDF_HI 7
`define PTR_NDF_LO 4
`define PTR_SS_HI 3
`define PTR_SS_LO 2

// ---------------------------------------------------------------
// codes and ranges
// ---------------------------------------------------------------
`define PTR_SS_NORMAL 2'h2
`define PTR_SS_TU2 2'h0
`define PTR_MAX_AU4 10'h30E
`define PTR_MAX_TU3 10'h2FC
`define PTR_MAX_TU2 10'h1AB
`define PTR_MAX_TU12 10'h08B
`define PTR_MAX_TU11 10'h067

// ---------------------------------------------------------------
// consecutive frame counts
// ---------------------------------------------------------------
`define PTR_CNT_W 4
`define PTR_AIS_RUN 4'h3
`define PTR_INV_RUN 4'h8
`define PTR_NDF_RUN 4'h8
`define PTR_NEW_RUN 4'h3
`define PTR_HOLD_RUN 4'h3

`endif

// file: rtl/ptr_pkg.sv
// types shared by the pointer interpreter modules
// assumes nothing beyond the defines header
`default_nettype none
package ptr_pkg;
	typedef enum logic [5:0] {
		PTR_NORM = 6'h01,
		PTR_AIS = 6'h02,
		PTR_LOP = 6'h04,
		PTR_INC = 6'h08,
		PTR_DEC = 6'h10,
		PTR_NDF = 6'h20
	} ptr_state_t;
	typedef enum logic [2:0] {
		PTR_T_AU4 = 3'h0,
		PTR_T_AU4XC = 3'h1,
		PTR_T_TU3 = 3'h2,
		PTR_T_TU2 = 3'h3,
		PTR_T_TU12 = 3'h4,
		PTR_T_TU11 = 3'h5
	} ptr_type_t;
endpackage
`default_nettype wire

// file: rtl/ptr_evt_if.sv
// per-frame pointer events from the classifier to the state machine
// assumes both ends sit on the same clock
`default_nettype none
interface ptr_evt_if;
	logic ais;
	logic norm;
	logic ndfe;
	logic inc;
	logic dec;
	logic newp;
	logic [9:0] rx_off;
	logic [9:0] max_off;
	modport cls (output ais, norm, ndfe, inc, dec, newp, rx_off, max_off);
	modport fsm (input ais, norm, ndfe, inc, dec, newp, rx_off, max_off);
endinterface
`default_nettype wire

// file: rtl/ptr_classify.sv
// combinational classifier of one received pointer word
// assumes active offset and its defined flag come from the state machine
`include "ptr_defines.svh"
`default_nettype none
module ptr_classify #(
	parameter logic [1:0] SS_TU11 = 2'h3
) (
	// pointer word
	input wire logic [7:0] h1,
	input wire logic [7:0] h2,
	// provisioning and context
	input wire ptr_pkg::ptr_type_t ptype,
	input wire logic type_mism,
	input wire logic [9:0] act_off,
	input wire logic off_def,
	// events
	ptr_evt_if.cls ev
);
	logic [3:0] ndf;
	logic [1:0] ss;
	logic [9:0] off;
	logic [9:0] diff;
	logic ndf_en, ndf_dis, ss_ok, in_rng, imaj, dmaj, ok;
	logic [1:0] ss_exp;
	logic chk_ss;
	logic [2:0] icnt, dcnt;

	assign ndf = h1[`PTR_NDF_HI:`PTR_NDF_LO];
	assign ss = h1[`PTR_SS_HI:`PTR_SS_LO];
	assign off = {h1[1:0], h2};
	assign diff = off ^ act_off;

	always_comb begin
		ndf_en = 1'b0;
		ndf_dis = 1'b0;
		unique case (ndf)
			4'h9, 4'h1, 4'hD, 4'hB, 4'h8: ndf_en = 1'b1;
			4'h6, 4'hE, 4'h2, 4'h4, 4'h7: ndf_dis = 1'b1;
			default: ; // remaining codes fall to invalid
		endcase
	end

	always_comb begin
		chk_ss = 1'b1;
		ss_exp = `PTR_SS_NORMAL;
		unique case (ptype)
			ptr_pkg::PTR_T_AU4, ptr_pkg::PTR_T_AU4XC: begin
				chk_ss = 1'b0;
				ev.max_off = `PTR_MAX_AU4;
			end
			ptr_pkg::PTR_T_TU3: ev.max_off = `PTR_MAX_TU3;
			ptr_pkg::PTR_T_TU2: begin
				ss_exp = `PTR_SS_TU2;
				ev.max_off = `PTR_MAX_TU2;
			end
			ptr_pkg::PTR_T_TU12: ev.max_off = `PTR_MAX_TU12;
			ptr_pkg::PTR_T_TU11: begin
				ss_exp = SS_TU11;
				ev.max_off = `PTR_MAX_TU11;
			end
			default: ev.max_off = `PTR_MAX_AU4;
		endcase
	end

	// I-bits are the odd offset bits, D-bits the even ones
	always_comb begin
		icnt = 3'h0;
		dcnt = 3'h0;
		for (int i = 0; i < 5; i++) begin
			icnt = icnt + {2'h0, diff[2*i+1]};
			dcnt = dcnt + {2'h0, diff[2*i]};
		end
	end

	assign imaj = icnt >= 3'h3;
	assign dmaj = dcnt >= 3'h3;
	assign ss_ok = !chk_ss || (ss == ss_exp);
	assign in_rng = off <= ev.max_off;
	// a provisioned type mismatch turns every frame except AIS invalid
	assign ok = ss_ok && !type_mism;

	assign ev.rx_off = off;
	assign ev.ais = ({h1, h2} == `PTR_AIS_WORD);
	assign ev.norm = ndf_dis && ok && off_def && (off == act_off);
	assign ev.ndfe = ndf_en && ok && in_rng;
	assign ev.inc = ndf_dis && ok && off_def && imaj && !dmaj;
	assign ev.dec = ndf_dis && ok && off_def && dmaj && !imaj;
	assign ev.newp = ndf_dis && ok && in_rng && (!off_def || off != act_off);
endmodule // ptr_classify
`default_nettype wire

// file: verif/ptr_gen_model.sv
// upstream pointer generator model: one pointer word per requested frame
// assumes the bench sets the request inputs on the falling clock edge
`default_nettype none
module ptr_gen_model #(
	parameter logic [1:0] SS_TU11 = 2'h3
) (
	// clock
	input wire logic clk,
	// frame request
	input wire logic en,
	input wire logic [1:0] kind,
	input wire logic [3:0] ndf,
	input wire logic [9:0] off,
	input wire ptr_pkg::ptr_type_t ptype,
	input wire logic ss_bad,
	// pointer out
	output logic valid,
	output logic [7:0] h1,
	output logic [7:0] h2
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] ss;
	logic [9:0] word_off;
	logic [7:0] idle_q = 8'h00;

	always @(posedge clk) begin
		idle_q <= idle_q + 8'h01;
	end

	always_comb begin
		case (ptype)
			ptr_pkg::PTR_T_TU2: ss = 2'h0;
			ptr_pkg::PTR_T_TU11: ss = SS_TU11;
			default: ss = 2'h2;
		endcase
		ss = ss ^ {1'b0, ss_bad};
		case (kind)
			2'h1: word_off = off ^ 10'h2AA;
			2'h2: word_off = off ^ 10'h155;
			default: word_off = off;
		endcase
		valid = en;
		if (!en) begin
			// released bytes change every cycle so stale data never looks valid
			h1 = idle_q;
			h2 = ~idle_q;
		end else if (kind == 2'h3) begin
			h1 = 8'hFF;
			h2 = 8'hFF;
		end else begin
			h1 = {ndf, ss, word_off[9:8]};
			h2 = word_off[7:0];
		end
	end
endmodule // ptr_gen_model
`default_nettype wire

// file: verif/sdh_pointer_interpreter_test.sv
// self-checking bench for the receive pointer interpreter
// assumes ptr_pkg, ptr_evt_if and the design modules are compiled first
`default_nettype none
module sdh_pointer_interpreter_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	typedef struct packed {ptr_pkg::ptr_state_t st; logic [9:0] off;} ptr_exp_t;
	localparam ptr_pkg::ptr_state_t S_NORM = ptr_pkg::PTR_NORM;
	localparam ptr_pkg::ptr_state_t S_AIS = ptr_pkg::PTR_AIS;
	localparam ptr_pkg::ptr_state_t S_LOP = ptr_pkg::PTR_LOP;
	localparam ptr_pkg::ptr_state_t S_INC = ptr_pkg::PTR_INC;
	localparam ptr_pkg::ptr_state_t S_DEC = ptr_pkg::PTR_DEC;
	localparam ptr_pkg::ptr_state_t S_NDF = ptr_pkg::PTR_NDF;
	localparam logic [3:0] EN_CODES [5] = '{4'h9, 4'h1, 4'hD, 4'hB, 4'h8};
	localparam logic [3:0] DIS_CODES [5] = '{4'h6, 4'hE, 4'h2, 4'h4, 4'h7};
	localparam logic [3:0] INV_CODES [6] = '{4'h0, 4'h3, 4'h5, 4'hA, 4'hC, 4'hF};
	localparam ptr_pkg::ptr_type_t TYPES [6] = '{ptr_pkg::PTR_T_AU4, ptr_pkg::PTR_T_AU4XC,
		ptr_pkg::PTR_T_TU3, ptr_pkg::PTR_T_TU2, ptr_pkg::PTR_T_TU12, ptr_pkg::PTR_T_TU11};
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic g_en = 1'b0;
	logic [1:0] g_kind = 2'h0;
	logic [3:0] g_ndf = 4'h6;
	logic [9:0] g_off = 10'h000;
	logic g_ss_bad = 1'b0;
	logic ss_bad_nx = 1'b0;
	logic mism = 1'b0;
	logic mism_nx = 1'b0;
	ptr_pkg::ptr_type_t ptype = ptr_pkg::PTR_T_AU4;
	logic ptr_valid;
	logic [7:0] ptr_h1;
	logic [7:0] ptr_h2;
	logic ais_def;
	logic lop_def;
	logic off_valid;
	logic [9:0] act_off;
	ptr_pkg::ptr_state_t state;
	ptr_exp_t exp_q [$];
	ptr_exp_t mon_e;
	logic seen = 1'b0;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [9:0] cur = 10'h000;
	logic [9:0] a_off;
	logic [9:0] b_off;

	always #4 mclk = ~mclk;

	ptr_gen_model gen_u (.clk(mclk), .en(g_en), .kind(g_kind), .ndf(g_ndf), .off(g_off),
		.ptype(ptype), .ss_bad(g_ss_bad), .valid(ptr_valid), .h1(ptr_h1), .h2(ptr_h2));

	ptr_interp dut_u (.MCLK(mclk), .RST_N(rst_n), .PTR_VALID(ptr_valid), .PTR_H1(ptr_h1),
		.PTR_H2(ptr_h2), .PTR_TYPE(ptype), .TYPE_MISMATCH(mism), .AIS_DEFECT(ais_def),
		.LOP_DEFECT(lop_def), .ACT_OFFSET(act_off), .OFFSET_VALID(off_valid),
		.OFFSET_JUMP(), .STATE(state));

	// ----------------------------------------
	// compare and drive tasks
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic fail(input string what, input logic [15:0] got, input logic [15:0] exp);
		bad_count++;
		$display("[FAIL] t=%0t %s got=%h exp=%h", $time, what, got, exp);
	endtask

	task automatic cmp_st(input ptr_pkg::ptr_state_t got, input ptr_pkg::ptr_state_t exp);
		total_checks++;
		if (got !== exp) fail("state", {10'h000, got}, {10'h000, exp});
	endtask

	task automatic cmp_flags(input logic [2:0] got, input logic [2:0] exp);
		total_checks++;
		if (got !== exp) fail("flags", {13'h0000, got}, {13'h0000, exp});
	endtask

	task automatic cmp_off(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) fail("offset", {6'h00, got}, {6'h00, exp});
	endtask

	// frames go back to back; idle() releases the request
	task automatic frame(input logic [1:0] kind, input logic [3:0] ndf, input logic [9:0] off,
		input ptr_pkg::ptr_state_t st, input logic [9:0] eo);
		@(negedge mclk);
		g_en = 1'b1;
		g_kind = kind;
		g_ndf = ndf;
		g_off = off;
		g_ss_bad = ss_bad_nx;
		mism = mism_nx;
		exp_q.push_back('{st: st, off: eo});
	endtask

	task automatic idle();
		@(negedge mclk);
		g_en = 1'b0;
		@(negedge mclk);
	endtask

	task automatic settle(input logic [3:0] code, input ptr_pkg::ptr_state_t s);
		frame(2'h0, code, cur, s, cur);
		frame(2'h0, code, cur, s, cur);
		frame(2'h0, code, cur, S_NORM, cur);
	endtask

	task automatic do_reset(input ptr_pkg::ptr_type_t t);
		@(negedge mclk);
		rst_n = 1'b0;
		ptype = t;
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		@(negedge mclk);
		cmp_st(state, S_LOP);
	endtask

	// ----------------------------------------
	// monitor and timeout
	// ----------------------------------------
	always @(posedge mclk) begin
		seen <= ptr_valid & rst_n;
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			test_done();
		end
	end

	always @(negedge mclk) begin
		if (seen && exp_q.size() > 0) begin
			mon_e = exp_q.pop_front();
			cmp_st(state, mon_e.st);
			cmp_flags({ais_def, lop_def, off_valid},
				{mon_e.st == S_AIS, mon_e.st == S_LOP, mon_e.st == S_NORM});
			if (mon_e.st == S_NORM) cmp_off(act_off, mon_e.off);
		end
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'hc127_af5c));
		do_reset(ptr_pkg::PTR_T_AU4);
		for (int i = 0; i < 5; i++) begin
			cur = 10'($urandom % 783);
			frame(2'h0, EN_CODES[i], cur, S_NDF, cur);
			settle(DIS_CODES[i], S_NDF);
		end
		frame(2'h0, 4'h9, 10'h30F, S_NORM, cur);
		$display("test codes done");
		cur = 10'h30E;
		frame(2'h0, 4'h9, cur, S_NDF, cur);
		settle(4'h6, S_NDF);
		frame(2'h1, 4'h6, cur, S_INC, cur);
		cur = 10'h000;
		frame(2'h1, 4'h6, cur, S_INC, cur);
		frame(2'h0, 4'h6, cur, S_INC, cur);
		frame(2'h0, 4'h6, cur, S_NORM, cur);
		frame(2'h1, 4'h6, cur, S_INC, cur);
		cur = 10'h001;
		settle(4'h6, S_INC);
		frame(2'h2, 4'h6, cur, S_DEC, cur);
		cur = 10'h000;
		settle(4'h6, S_DEC);
		$display("test inc dec done");
		frame(2'h3, 4'h0, 10'h000, S_NORM, cur);
		frame(2'h3, 4'h0, 10'h000, S_NORM, cur);
		frame(2'h0, 4'h6, cur, S_NORM, cur);
		frame(2'h3, 4'h0, 10'h000, S_NORM, cur);
		frame(2'h3, 4'h0, 10'h000, S_NORM, cur);
		frame(2'h3, 4'h0, 10'h000, S_AIS, cur);
		cur = 10'($urandom % 783);
		frame(2'h0, 4'h9, cur, S_NDF, cur);
		settle(4'h6, S_NDF);
		$display("test ais done");
		for (int i = 0; i < 7; i++) frame(2'h0, INV_CODES[i % 6], cur, S_NORM, cur);
		frame(2'h0, 4'h6, cur, S_NORM, cur);
		for (int i = 0; i < 8; i++) begin
			frame(2'h0, INV_CODES[i % 6], cur, (i == 7) ? S_LOP : S_NORM, cur);
		end
		$display("test lop done");
		// below 512 so that the two flipped-bit offsets stay in range
		cur = 10'($urandom % 512);
		frame(2'h0, 4'h6, cur, S_LOP, cur);
		frame(2'h0, 4'h6, cur, S_LOP, cur);
		frame(2'h0, 4'h6, cur, S_NORM, cur);
		// one I-bit and one D-bit differ: never a majority, so never inc or dec
		a_off = cur ^ 10'h003;
		b_off = cur ^ 10'h00C;
		frame(2'h0, 4'h0, cur, S_NORM, cur);
		frame(2'h0, 4'h0, cur, S_NORM, cur);
		frame(2'h0, 4'h6, a_off, S_NORM, cur);
		frame(2'h0, 4'h6, a_off, S_NORM, cur);
		frame(2'h0, 4'h6, b_off, S_NORM, cur);
		frame(2'h0, 4'h6, b_off, S_NORM, cur);
		cur = b_off;
		frame(2'h0, 4'h6, cur, S_NORM, cur);
		frame(2'h0, 4'h0, cur, S_NORM, cur);
		frame(2'h0, 4'h6, cur, S_NORM, cur);
		$display("test new pointer done");
		mism_nx = 1'b1;
		for (int i = 0; i < 8; i++) frame(2'h0, 4'h6, cur, (i == 7) ? S_LOP : S_NORM, cur);
		mism_nx = 1'b0;
		idle();
		$display("test type mismatch done");
		for (int i = 0; i < 6; i++) begin
			do_reset(TYPES[i]);
			ss_bad_nx = 1'b1;
			frame(2'h0, 4'h9, 10'h010, (i < 2) ? S_NDF : S_LOP, 10'h010);
			ss_bad_nx = 1'b0;
			frame(2'h0, 4'h9, 10'h010, S_NDF, 10'h010);
			idle();
		end
		$display("test ss bits done");
		test_done();
	end
endmodule // sdh_pointer_interpreter_test
`default_nettype wire
